// File: hw/dma_channel_control.sv
// four-channel dma controller with apb registers and dual-address engine
// ----------------------------------------
// Overview of operation
// - four independent channels, each with own settings
// - go bit write activates channel into ready
// - request takes bus, transfers, then releases it
// - finished channel returns to idle state
// - source and destination step independently per unit
// - counting starts at bit 0,4,8,12 or 16
// - position zero gives ordinary unit step
// - per channel internal or external request select
// - internal request holds until channel completes
// - external request line starts ready channel transfer
// - request line by edge or level, polarity
// - one I/O request moves one 32/16/8-bit unit
// - acknowledge clears request; memory pairs only at zero
// - I/O one unit per request; memory runs on
// - request cleared late may still give one transfer
// - read into holding register, then write it out
// - count codes 000..100 map bits; rest reserved
// - acknowledge asserted on every I/O access
// ----------------------------------------
`include "dma_channel_consts.svh"
module dma_channel_control #(
    parameter int NCH = 4,
    parameter int AW = 32
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NCH-1:0] dma_request_line_n,
    output logic [NCH-1:0] channel_acknowledge,
    output logic bus_request,
    input wire logic bus_grant,
    output logic mem_req,
    output logic mem_we,
    output logic [AW-1:0] mem_addr,
    output logic [1:0] mem_size,
    output logic [31:0] mem_wdata,
    input wire logic [31:0] mem_rdata,
    input wire logic mem_ready
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [31:0] channel_control_reg [NCH];
    logic [5:0] transfer_control_reg [NCH];
    logic [AW-1:0] src_addr [NCH];
    logic [AW-1:0] dst_addr [NCH];
    logic [31:0] byte_count_reg [NCH];
    logic [NCH-1:0] act, st_normal, st_abnormal, st_config;
    logic [NCH-1:0] line_q, edge_pend, run;
    logic [31:0] holding_register;
    dma_channel_pkg::engine_state_t eng;
    logic [1:0] cur;

    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    logic [1:0] ach;
    logic [4:0] aofs;
    logic mapped, wr_en, rd_setup;
    logic [NCH-1:0] go_wr, go_ok, st_wr;
    assign ach = paddr[6:5];
    assign aofs = paddr[4:0];
    assign mapped = !paddr[7] && (aofs == `OFS_CONTROL || aofs == `OFS_XFER_CTL || aofs == `OFS_SRC_ADDR
        || aofs == `OFS_DST_ADDR || aofs == `OFS_BYTE_CNT || aofs == `OFS_STATUS);
    assign wr_en = psel && penable && pwrite && mapped;
    assign rd_setup = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    function automatic logic [2:0] unit_of(input logic [1:0] sz);
        unique case (sz)
            `SIZE_16: unit_of = 3'h2;
            `SIZE_8: unit_of = 3'h1;
            default: unit_of = 3'h4;
        endcase
    endfunction : unit_of

    // configuration check at go, new settings written with it
    logic [2:0] wunit;
    logic [31:0] wmask;
    assign wunit = unit_of(pwdata[`CC_SIZE_LO +: 2]);
    assign wmask = 32'(wunit) - 32'h0000_0001;
    for (genvar i = 0; i < NCH; i++) begin : g_go
        logic err;
        assign go_wr[i] = wr_en && ach == 2'(i) && aofs == `OFS_CONTROL && pwdata[`CC_GO] && !act[i];
        assign st_wr[i] = wr_en && ach == 2'(i) && aofs == `OFS_STATUS;
        assign err = (pwdata[`CC_SRC_IO] && pwdata[`CC_DST_IO]) || byte_count_reg[i] == 32'h0000_0000
            || (byte_count_reg[i] & wmask) != 32'h0000_0000 || (32'(src_addr[i]) & wmask) != 32'h0000_0000
            || (32'(dst_addr[i]) & wmask) != 32'h0000_0000 || st_normal[i] || st_abnormal[i];
        assign go_ok[i] = go_wr[i] && !err;
    end

    // ----------------------------------------
    // per-channel fields of the engine's channel
    // ----------------------------------------
    logic [31:0] cc;
    logic [2:0] unit;
    logic src_io, dst_io, m2m, last;
    logic [AW-1:0] src_next, dst_next;
    assign cc = channel_control_reg[cur];
    assign unit = unit_of(cc[`CC_SIZE_LO +: 2]);
    assign src_io = cc[`CC_SRC_IO];
    assign dst_io = cc[`CC_DST_IO];
    assign m2m = !src_io && !dst_io;
    assign last = byte_count_reg[cur] == 32'(unit);
    assign mem_size = cc[`CC_SIZE_LO +: 2];

    address_step #(.AW(AW)) u_src_step (
        .addr(src_addr[cur]),
        .mode(cc[`CC_SRC_STEP_LO +: 2]),
        .pos(transfer_control_reg[cur][`TC_SRC_POS_LO +: 3]),
        .unit(unit),
        .next_addr(src_next)
    );
    address_step #(.AW(AW)) u_dst_step (
        .addr(dst_addr[cur]),
        .mode(cc[`CC_DST_STEP_LO +: 2]),
        .pos(transfer_control_reg[cur][`TC_DST_POS_LO +: 3]),
        .unit(unit),
        .next_addr(dst_next)
    );

    // ----------------------------------------
    // request recognition
    // ----------------------------------------
    logic [NCH-1:0] req, lvl, hit, taken, done;
    logic any_req;
    logic [1:0] pick;
    logic unit_end;
    assign unit_end = eng == dma_channel_pkg::E_WRITE && mem_ready;
    for (genvar i = 0; i < NCH; i++) begin : g_req
        // line is active low; polarity bit turns the sense round
        assign lvl[i] = channel_control_reg[i][`CC_POLARITY] ? dma_request_line_n[i] : !dma_request_line_n[i];
        assign hit[i] = channel_control_reg[i][`CC_EDGE] ? edge_pend[i] : lvl[i];
        assign req[i] = act[i] && (!channel_control_reg[i][`CC_EXT_REQ] || run[i] || hit[i]);
        assign taken[i] = (eng == dma_channel_pkg::E_IDLE && any_req && pick == 2'(i));
        assign done[i] = unit_end && cur == 2'(i) && last;
    end
    assign any_req = |req;

    always_comb begin
        // fixed priority, lowest channel first
        pick = 2'h0;
        for (int k = NCH - 1; k >= 0; k--) begin
            if (req[k]) begin
                pick = 2'(k);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_q <= '1;
            edge_pend <= '0;
        end else begin
            line_q <= dma_request_line_n;
            for (int i = 0; i < NCH; i++) begin
                // new edge beats the clear of an old one
                if (act[i] && (channel_control_reg[i][`CC_POLARITY] ? (dma_request_line_n[i] && !line_q[i])
                        : (!dma_request_line_n[i] && line_q[i]))) begin
                    edge_pend[i] <= 1'b1;
                end else if (taken[i] || !act[i]) begin
                    edge_pend[i] <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------
    // channel state and status
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act <= '0;
            run <= '0;
            st_normal <= '0;
            st_abnormal <= '0;
            st_config <= '0;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (go_ok[i]) begin
                    act[i] <= 1'b1;
                end else if (done[i]) begin
                    act[i] <= 1'b0;
                end
                // memory pairs keep running on one request until zero
                if (taken[i] && !channel_control_reg[i][`CC_SRC_IO] && !channel_control_reg[i][`CC_DST_IO]) begin
                    run[i] <= 1'b1;
                end else if (done[i] || !act[i]) begin
                    run[i] <= 1'b0;
                end
                if (done[i]) begin
                    st_normal[i] <= 1'b1;
                end else if (st_wr[i] && pwdata[`ST_NORMAL]) begin
                    st_normal[i] <= 1'b0;
                end
                if (go_wr[i] && !go_ok[i]) begin
                    st_abnormal[i] <= 1'b1;
                    st_config[i] <= 1'b1;
                end else if (st_wr[i]) begin
                    st_abnormal[i] <= st_abnormal[i] && !pwdata[`ST_ABNORMAL];
                    st_config[i] <= st_config[i] && !pwdata[`ST_CONFIG];
                end
            end
        end
    end

    // ----------------------------------------
    // channel settings and counters
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NCH; i++) begin
                channel_control_reg[i] <= `CC_RESET;
                transfer_control_reg[i] <= 6'h00;
                src_addr[i] <= '0;
                dst_addr[i] <= '0;
                byte_count_reg[i] <= 32'h0000_0000;
            end
        end else begin
            // settings of a running channel are not writable
            if (wr_en && !act[ach]) begin
                unique case (aofs)
                    `OFS_CONTROL: channel_control_reg[ach] <= {pwdata[31:1], 1'b0};
                    `OFS_XFER_CTL: transfer_control_reg[ach] <= pwdata[5:0];
                    `OFS_SRC_ADDR: src_addr[ach] <= AW'(pwdata);
                    `OFS_DST_ADDR: dst_addr[ach] <= AW'(pwdata);
                    `OFS_BYTE_CNT: byte_count_reg[ach] <= pwdata;
                    default: ;
                endcase
            end
            if (eng == dma_channel_pkg::E_READ && mem_ready) begin
                src_addr[cur] <= src_next;
            end
            if (unit_end) begin
                dst_addr[cur] <= dst_next;
                byte_count_reg[cur] <= byte_count_reg[cur] - 32'(unit);
            end
        end
    end

    // ----------------------------------------
    // transfer engine
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eng <= dma_channel_pkg::E_IDLE;
            cur <= 2'h0;
            bus_request <= 1'b0;
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_addr <= '0;
            mem_wdata <= 32'h0000_0000;
            holding_register <= 32'h0000_0000;
        end else begin
            unique case (eng)
                dma_channel_pkg::E_IDLE: begin
                    if (any_req) begin
                        cur <= pick;
                        bus_request <= 1'b1;
                        eng <= dma_channel_pkg::E_WAIT_GRANT;
                    end
                end
                dma_channel_pkg::E_WAIT_GRANT: begin
                    if (bus_grant) begin
                        mem_req <= 1'b1;
                        mem_we <= 1'b0;
                        mem_addr <= src_addr[cur];
                        eng <= dma_channel_pkg::E_READ;
                    end
                end
                dma_channel_pkg::E_READ: begin
                    if (mem_ready) begin
                        holding_register <= mem_rdata;
                        mem_wdata <= mem_rdata;
                        mem_we <= 1'b1;
                        mem_addr <= dst_addr[cur];
                        eng <= dma_channel_pkg::E_WRITE;
                    end
                end
                dma_channel_pkg::E_WRITE: begin
                    if (mem_ready) begin
                        if (m2m && !last) begin
                            // back to back, bus kept; source already stepped at read end
                            mem_we <= 1'b0;
                            mem_addr <= src_addr[cur];
                            eng <= dma_channel_pkg::E_READ;
                        end else begin
                            mem_req <= 1'b0;
                            mem_we <= 1'b0;
                            bus_request <= 1'b0;
                            eng <= dma_channel_pkg::E_RELEASE;
                        end
                    end
                end
                dma_channel_pkg::E_RELEASE: begin
                    // one spare cycle lets a level request fall after the acknowledge
                    eng <= dma_channel_pkg::E_IDLE;
                end
                default: eng <= dma_channel_pkg::E_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // acknowledge
    // ----------------------------------------
    logic io_access;
    assign io_access = mem_req && ((eng == dma_channel_pkg::E_READ && src_io)
        || (eng == dma_channel_pkg::E_WRITE && dst_io));
    always_comb begin
        channel_acknowledge = '0;
        if (io_access || (m2m && eng == dma_channel_pkg::E_WRITE && mem_req && last)) begin
            channel_acknowledge[cur] = 1'b1;
        end
    end

    // ----------------------------------------
    // read data
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata <= 32'h0000_0000;
            if (mapped) begin
                unique case (aofs)
                    `OFS_CONTROL: prdata <= {channel_control_reg[ach][31:1], act[ach]};
                    `OFS_XFER_CTL: prdata <= {26'h0, transfer_control_reg[ach]};
                    `OFS_SRC_ADDR: prdata <= 32'(src_addr[ach]);
                    `OFS_DST_ADDR: prdata <= 32'(dst_addr[ach]);
                    `OFS_BYTE_CNT: prdata <= byte_count_reg[ach];
                    default: prdata <= {28'h0, st_config[ach], st_abnormal[ach], st_normal[ach], act[ach]};
                endcase
            end
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    sequence s_read_done;
        mem_req && !mem_we && mem_ready;
    endsequence
    sequence s_write_issued;
        mem_req && mem_we && mem_wdata == holding_register;
    endsequence

    a_grant_before_access: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(mem_req) |-> bus_request && $past(bus_grant)) else $error("access without grant");
    a_read_then_write: assert property (@(posedge pclk) disable iff (!presetn)
        s_read_done |=> s_write_issued and mem_wdata == $past(mem_rdata)) else $error("holding data lost");
    a_go_activates: assert property (@(posedge pclk) disable iff (!presetn)
        go_ok[0] |=> act[0]) else $error("go did not activate");
    a_done_to_idle: assert property (@(posedge pclk) disable iff (!presetn)
        unit_end && last |=> !act[$past(cur)] && st_normal[$past(cur)]) else $error("channel not idle");
    a_io_acknowledge: assert property (@(posedge pclk) disable iff (!presetn)
        io_access |-> channel_acknowledge == (4'h1 << cur)) else $error("i/o access without acknowledge");
    a_m2m_no_ack: assert property (@(posedge pclk) disable iff (!presetn)
        m2m && eng == dma_channel_pkg::E_WRITE && !last |-> channel_acknowledge == 4'h0) else $error("early ack");
    a_release_bus: assert property (@(posedge pclk) disable iff (!presetn)
        eng == dma_channel_pkg::E_RELEASE |-> !bus_request && !mem_req) else $error("bus held");
    a_internal_start: assert property (@(posedge pclk) disable iff (!presetn)
        go_ok[0] && !pwdata[`CC_EXT_REQ] && eng == dma_channel_pkg::E_IDLE && act == 4'h0
        |=> ##1 bus_request) else $error("internal request not raised");
    a_count_step: assert property (@(posedge pclk) disable iff (!presetn)
        unit_end |=> byte_count_reg[$past(cur)] == $past(byte_count_reg[cur]) - 32'($past(unit)))
        else $error("count step wrong");
    a_pos_step: assert property (@(posedge pclk) disable iff (!presetn)
        unit_end && cc[`CC_DST_STEP_LO +: 2] == `STEP_INC && transfer_control_reg[cur][`TC_DST_POS_LO +: 3] == 3'h1
        |=> dst_addr[$past(cur)] == $past(dst_addr[cur]) + AW'(16)) else $error("bit 4 step wrong");
endmodule : dma_channel_control

// File: hw/dma_channel_consts.svh
// register offsets, field positions, reset values and codes of the dma channel block
`ifndef DMA_CHANNEL_CONSTS_SVH
`define DMA_CHANNEL_CONSTS_SVH
// ----------------------------------------
// register map, one 0x20 window per channel
// ----------------------------------------
`define CH_STRIDE_LOG2 5
`define OFS_CONTROL 5'h00
`define OFS_XFER_CTL 5'h04
`define OFS_SRC_ADDR 5'h08
`define OFS_DST_ADDR 5'h0C
`define OFS_BYTE_CNT 5'h10
`define OFS_STATUS 5'h14
// ----------------------------------------
// channel_control_reg fields
// ----------------------------------------
`define CC_GO 0
`define CC_EXT_REQ 1
`define CC_POLARITY 2
`define CC_EDGE 3
`define CC_SIZE_LO 4
`define CC_SRC_STEP_LO 6
`define CC_DST_STEP_LO 8
`define CC_SRC_IO 10
`define CC_DST_IO 11
`define CC_ADDR_MODE 15
`define CC_RESET 32'h0000_0000
// ----------------------------------------
// transfer_control_reg and status fields
// ----------------------------------------
`define TC_SRC_POS_LO 0
`define TC_DST_POS_LO 3
`define ST_ACTIVE 0
`define ST_NORMAL 1
`define ST_ABNORMAL 2
`define ST_CONFIG 3
// ----------------------------------------
// codes
// ----------------------------------------
`define STEP_FIXED 2'h0
`define STEP_INC 2'h1
`define STEP_DEC 2'h2
`define SIZE_16 2'h2
`define SIZE_8 2'h3
`define POS_BIT0 3'h0
`define POS_BIT16 3'h4
`endif

// File: hw/dma_channel_pkg.sv
// types shared by the dma channel block
package dma_channel_pkg;
    typedef enum logic [2:0] {
        E_IDLE,
        E_WAIT_GRANT,
        E_READ,
        E_WRITE,
        E_RELEASE
    } engine_state_t;
endpackage : dma_channel_pkg

// File: hw/address_step.sv
// next-address computation for one address counter
`include "dma_channel_consts.svh"
module address_step #(
    parameter int AW = 32
) (
    input wire logic [AW-1:0] addr,
    input wire logic [1:0] mode,
    input wire logic [2:0] pos,
    input wire logic [2:0] unit,
    output logic [AW-1:0] next_addr
);
    logic [AW-1:0] step;

    always_comb begin
        // positions 0 and 5-7 step by the unit, 1-4 from the selected bit
        if (pos == `POS_BIT0 || pos > `POS_BIT16) begin
            step = AW'(unit);
        end else begin
            step = AW'(1) << (4 * pos);
        end
        unique case (mode)
            `STEP_INC: next_addr = addr + step;
            `STEP_DEC: next_addr = addr - step;
            default: next_addr = addr;
        endcase
    end
endmodule : address_step

// File: testbench/far_side_model.sv
// core bus grant, memory and request-line source behind the dma block
module far_side_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic bus_request,
    output logic bus_grant,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    output logic [31:0] mem_rdata,
    output logic mem_ready,
    input wire logic [3:0] channel_acknowledge,
    output logic [3:0] dma_request_line_n
);
    timeunit 1ns;
    timeprecision 1ps;
    int wait_cycles = 0;
    int cnt;
    logic [3:0] pending;
    logic [3:0] set_mask = 4'h0;
    logic log_we[$];
    logic [31:0] log_addr[$];
    logic [31:0] log_data[$];
    logic [3:0] log_ack[$];
    // ----
    // request lines
    // ----
    // active low: an idle line sits high
    assign dma_request_line_n = ~pending;
    task automatic raise(input logic [3:0] m);
        @(posedge pclk);
        set_mask <= m;
        @(posedge pclk);
        set_mask <= 4'h0;
    endtask : raise
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pending <= 4'h0;
        end else begin
            pending <= (pending & ~channel_acknowledge) | set_mask;
        end
    end
    // ----
    // grant and memory
    // ----
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_grant <= 1'b0;
            mem_ready <= 1'b0;
            mem_rdata <= 32'h0000_0000;
            cnt <= 0;
        end else begin
            bus_grant <= bus_request;
            if (mem_ready) begin
                mem_ready <= 1'b0;
                // data only valid with ready, flip it so a late sample shows
                mem_rdata <= ~mem_rdata;
            end else if (mem_req && cnt >= wait_cycles) begin
                mem_ready <= 1'b1;
                mem_rdata <= {~mem_addr[15:0], mem_addr[15:0]};
                cnt <= 0;
                log_we.push_back(mem_we);
                log_addr.push_back(mem_addr);
                log_data.push_back(mem_wdata);
                log_ack.push_back(channel_acknowledge);
            end else if (mem_req) begin
                cnt <= cnt + 1;
            end
        end
    end
endmodule : far_side_model

// File: testbench/dma_channel_control_tb.sv
// self-checking bench for the dma channel block
module dma_channel_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk, presetn, psel, penable, pwrite, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, mem_addr, mem_wdata, mem_rdata, rd;
    logic pready, pslverr, bus_request, bus_grant, mem_req, mem_we, mem_ready;
    logic [3:0] dma_request_line_n, channel_acknowledge;
    logic [1:0] mem_size;
    int fails = 0;
    int tests_run = 0;
    dma_channel_control uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .dma_request_line_n(dma_request_line_n),
        .channel_acknowledge(channel_acknowledge), .bus_request(bus_request), .bus_grant(bus_grant),
        .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_size(mem_size),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ready(mem_ready));
    far_side_model far (.pclk(pclk), .presetn(presetn), .bus_request(bus_request),
        .bus_grant(bus_grant), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ready(mem_ready),
        .channel_acknowledge(channel_acknowledge), .dma_request_line_n(dma_request_line_n));
    // ----
    // helpers
    // ----
    function automatic logic [31:0] pat(input logic [31:0] a);
        return {~a[15:0], a[15:0]};
    endfunction : pat
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n == 50) fails++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic cfg(input logic [7:0] b, input logic [31:0] s, input logic [31:0] d,
        input logic [31:0] c, input logic [31:0] tc, input logic [31:0] ctl);
        apb(1'b1, b + 8'h08, s);
        apb(1'b1, b + 8'h0C, d);
        apb(1'b1, b + 8'h10, c);
        apb(1'b1, b + 8'h04, tc);
        apb(1'b1, b, ctl);
    endtask : cfg
    task automatic wait_log(input int k);
        int n;
        n = 0;
        while (far.log_addr.size() < k && n < 500) begin
            @(posedge pclk);
            n++;
        end
        if (n == 500) fails++;
    endtask : wait_log
    task automatic wait_idle(input logic [7:0] b);
        int n;
        n = 0;
        do begin
            apb(1'b0, b + 8'h14, 32'h0000_0000);
            n++;
        end while (rd[0] !== 1'b0 && n < 100);
    endtask : wait_idle
    task automatic acc(input logic we, input logic [31:0] a, input logic [31:0] d, input logic [3:0] k);
        logic [31:0] wd;
        check({31'h0, far.log_we.pop_front()}, {31'h0, we});
        check(far.log_addr.pop_front(), a);
        wd = far.log_data.pop_front();
        if (we) check(wd, d);
        check({28'h0, far.log_ack.pop_front()}, {28'h0, k});
    endtask : acc
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    // ----
    // clock, watchdog, tests
    // ----
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        tally_and_finish();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h14, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        check({31'h0, bus_request}, 32'h0000_0000);
        $display("test reset done");
        // memory copy, regular source and bit-4 destination stepping
        cfg(8'h00, 32'h1000, 32'h2000, 32'h10, 32'h08, 32'h141);
        wait_log(8);
        for (int i = 0; i < 4; i++) begin
            acc(1'b0, 32'h1000 + 4 * i, 32'h0, 4'h0);
            acc(1'b1, 32'h2000 + 16 * i, pat(32'h1000 + 4 * i), (i == 3) ? 4'h1 : 4'h0);
        end
        wait_idle(8'h00);
        check(rd, 32'h0000_0002);
        check({31'h0, bus_request}, 32'h0000_0000);
        $display("test increment done");
        // slow memory, halfword units stepping down
        far.wait_cycles = 3;
        cfg(8'h20, 32'h1000, 32'h3000, 32'h4, 32'h02, 32'h2A1);
        wait_log(4);
        acc(1'b0, 32'h1000, 32'h0, 4'h0);
        acc(1'b1, 32'h3000, pat(32'h1000), 4'h0);
        acc(1'b0, 32'h0F00, 32'h0, 4'h0);
        acc(1'b1, 32'h2FFE, pat(32'h0F00), 4'h2);
        wait_idle(8'h20);
        check(rd, 32'h0000_0002);
        $display("test decrement done");
        // i/o source, byte units, one unit per request
        far.wait_cycles = 0;
        cfg(8'h40, 32'h4000, 32'h5000, 32'h2, 32'h00, 32'h533);
        repeat (20) @(posedge pclk);
        check(32'(far.log_addr.size()), 32'h0000_0000);
        for (int i = 0; i < 2; i++) begin
            far.raise(4'h4);
            wait_log(2);
            repeat (20) @(posedge pclk);
            check(32'(far.log_addr.size()), 32'h0000_0002);
            check({28'h0, far.pending}, 32'h0000_0000);
            acc(1'b0, 32'h4000, 32'h0, 4'h4);
            acc(1'b1, 32'h5000 + i, pat(32'h4000), 4'h0);
        end
        wait_idle(8'h40);
        check(rd, 32'h0000_0002);
        $display("test external done");
        // refusals: unmapped place and zero count
        apb(1'b1, 8'h80, 32'hFFFF_FFFF);
        check({31'h0, err}, 32'h0000_0001);
        apb(1'b0, 8'h80, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        apb(1'b1, 8'h60, 32'h0000_0001);
        apb(1'b0, 8'h74, 32'h0000_0000);
        check(rd, 32'h0000_000C);
        apb(1'b1, 8'h74, 32'h0000_000E);
        apb(1'b0, 8'h74, 32'h0000_0000);
        check(rd, 32'h0000_0000);
        $display("test refusal done");
        // edge mode on the i/o line, one byte per falling edge
        cfg(8'h60, 32'h4000, 32'h6000, 32'h1, 32'h00, 32'h53B);
        far.raise(4'h8);
        wait_log(2);
        acc(1'b0, 32'h4000, 32'h0, 4'h8);
        acc(1'b1, 32'h6000, pat(32'h4000), 4'h0);
        wait_idle(8'h60);
        check(rd, 32'h0000_0002);
        check({30'h0, mem_size}, 32'h0000_0003);
        $display("test edge done");
        tally_and_finish();
    end
endmodule : dma_channel_control_tb
